/* File: src/emd_pkg.sv */
// Purpose: Shared constants and types of the external memory and DMA block.
// Assumes: 16-bit register port with a 4-bit word address.
// Notes: Register offsets are word indices on the plain register port.
`default_nettype none
package emd_pkg;
    // Register map.
    localparam logic [3:0] REG_OVERLAY = 4'h0;
    localparam logic [3:0] REG_WAITS = 4'h1;
    localparam logic [3:0] REG_IO_WAITS = 4'h2;
    localparam logic [3:0] REG_SEL_EN = 4'h3;
    localparam logic [3:0] REG_XFER_CTRL = 4'h4;
    localparam logic [3:0] REG_XFER_INT = 4'h5;
    localparam logic [3:0] REG_XFER_EXT = 4'h6;
    localparam logic [3:0] REG_XFER_PAGE = 4'h7;
    localparam logic [3:0] REG_XFER_COUNT = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    // Field positions.
    localparam int DATA_EXT_WAIT_LSB = 0;
    localparam int BWAIT_LSB = 3;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_HOLD_BIT = 3;
    localparam int SEL_PM = 0;
    localparam int SEL_DM = 1;
    localparam int SEL_BM = 2;
    localparam int SEL_IO = 3;
    localparam int IO_REGION_LSB = 9;
    // Reset value of the select enables, and the overlay-two setting.
    localparam logic [3:0] SEL_EN_RESET = 4'hb;
    localparam logic [1:0] OVERLAY_TWO = 2'h2;
    // Transfer formats.
    localparam logic [1:0] FMT_PM24 = 2'h0;
    localparam logic [1:0] FMT_DM16 = 2'h1;
    localparam logic [1:0] FMT_MSB = 2'h2;
    // Extra strobe cycles that cover the two-stage data synchroniser.
    localparam logic [3:0] SYNC_CYCLES = 4'h2;
    typedef enum logic [2:0] {
        B_IDLE = 3'b000,
        B_FETCH = 3'b001,
        B_LOAD = 3'b010,
        B_BYTE = 3'b011,
        B_STORE = 3'b100
    } emd_bstate_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SYNC = 2'b01,
        H_ACC = 2'b10,
        H_DONE = 2'b11
    } emd_hstate_t;
endpackage
`default_nettype wire

/* File: src/emd_top.sv */
// Purpose: Overlay decode, wait states, composite select, byte DMA, host DMA.
// Assumes: One processor clock; pins pass two flip-flops before use.
// Notes: External accesses last their wait count plus two sync cycles.
`default_nettype none
module emd_top
    import emd_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port.
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // Core external access port.
    input wire logic CORE_PM_REQ,
    input wire logic CORE_DM_REQ,
    input wire logic CORE_IO_REQ,
    input wire logic CORE_WE,
    input wire logic [13:0] CORE_ADDR,
    input wire logic [15:0] CORE_WDATA,
    output logic [15:0] CORE_RDATA,
    output logic CORE_WAIT,
    output logic CORE_DM_INTERNAL,
    output logic CORE_HOLD,
    output logic CORE_RESTART,
    output logic BYTE_DMA_IRQ,
    input wire logic BUS_GRANT,
    // External bus pins.
    output logic [13:0] EXT_ADDR,
    output logic [23:0] EXT_DATA_O,
    input wire logic [23:0] EXT_DATA_I,
    output logic [2:0] EXT_DATA_OE,
    output logic PIN_OE,
    output logic RD_N,
    output logic WR_N,
    output logic PMS_N,
    output logic DMS_N,
    output logic BMS_N,
    output logic IO_SPACE_STROBE_N,
    output logic CMS_N,
    // On-chip memory port.
    output logic MEM_REQ,
    output logic MEM_PM,
    output logic MEM_WE,
    output logic [13:0] MEM_ADDR,
    output logic [23:0] MEM_WDATA,
    input wire logic [23:0] MEM_RDATA,
    // Host DMA port pins.
    input wire logic HOST_ADDR_LATCH_N,
    input wire logic HOST_SELECT_N,
    input wire logic HOST_READ_N,
    input wire logic HOST_WRITE_N,
    input wire logic [15:0] HOST_AD_I,
    output logic [15:0] HOST_AD_O,
    output logic HOST_AD_OE,
    output logic HOST_ACK_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    function automatic logic [1:0] last_byte(input logic [1:0] fmt);
        last_byte = (fmt == FMT_PM24) ? 2'h2
            : (fmt == FMT_DM16) ? 2'h1 : 2'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] overlay_q;
    logic [2:0] data_ext_wait_q, bwait_q;
    logic [11:0] io_wait_q;
    logic [3:0] sel_en_q;
    logic [1:0] fmt_q;
    logic dir_q, hold_q;
    logic [13:0] int_q, ext_q, count_q;
    logic [7:0] page_q;
    logic [15:0] rdata_q;
    emd_bstate_t bst_q;
    emd_hstate_t hst_q;
    logic bact_q, word_done, byte_end, irq_q, restart_q, host_acc;
    logic [3:0] bcnt_q, ccnt_q, core_target;
    logic [1:0] idx_q;
    logic [23:0] word_q, ext_s1, ext_s2, store_word;
    logic [13:0] haddr_q;
    logic hpm_q, hwe_q;
    logic [15:0] had_s1, had_s2, hrdata_q;
    logic [3:0] hp_s1, hp_s2;
    logic hlatch_s3, host_req;
    logic dm_ext, core_ext, core_drive, count_wr, sel_seen_q;
    logic [2:0] io_wait;

    assign count_wr = REG_WR && REG_ADDR == REG_XFER_COUNT;

    ////////////////////////////////////////////////////////////////////////
    // Software-written configuration.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            overlay_q <= 2'h0;
            data_ext_wait_q <= 3'h0;
            bwait_q <= 3'h0;
            io_wait_q <= 12'h000;
            sel_en_q <= SEL_EN_RESET;
            fmt_q <= FMT_PM24;
            dir_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                REG_OVERLAY: overlay_q <= REG_WDATA[1:0];
                REG_WAITS: begin
                    data_ext_wait_q <= REG_WDATA[DATA_EXT_WAIT_LSB +: 3];
                    bwait_q <= REG_WDATA[BWAIT_LSB +: 3];
                end
                REG_IO_WAITS: io_wait_q <= REG_WDATA[11:0];
                REG_SEL_EN: sel_en_q <= REG_WDATA[3:0];
                REG_XFER_CTRL: begin
                    fmt_q <= REG_WDATA[1:0];
                    dir_q <= REG_WDATA[CTRL_DIR_BIT];
                    hold_q <= REG_WDATA[CTRL_HOLD_BIT];
                end
                default: ;
            endcase
        end
    end

    // Readback is registered and shows only in the cycle after the strobe.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= 16'h0000;
        end else if (!REG_RD) begin
            rdata_q <= 16'h0000;
        end else begin
            unique case (REG_ADDR)
                REG_OVERLAY: rdata_q <= {14'h0000, overlay_q};
                REG_WAITS: rdata_q <= {10'h000, bwait_q, data_ext_wait_q};
                REG_IO_WAITS: rdata_q <= {4'h0, io_wait_q};
                REG_SEL_EN: rdata_q <= {12'h000, sel_en_q};
                REG_XFER_CTRL: rdata_q <= {12'h000, hold_q, dir_q, fmt_q};
                REG_XFER_INT: rdata_q <= {2'h0, int_q};
                REG_XFER_EXT: rdata_q <= {2'h0, ext_q};
                REG_XFER_PAGE: rdata_q <= {8'h00, page_q};
                REG_XFER_COUNT: rdata_q <= {2'h0, count_q};
                REG_STATUS: rdata_q <= {haddr_q, hpm_q, bst_q != B_IDLE};
                default: rdata_q <= 16'h0000;
            endcase
        end
    end
    assign REG_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Core external accesses.
    assign dm_ext = CORE_DM_REQ && overlay_q != 2'h0
        && !CORE_ADDR[13];
    assign CORE_DM_INTERNAL = CORE_DM_REQ && !dm_ext;
    assign core_ext = dm_ext || CORE_IO_REQ || CORE_PM_REQ;
    assign io_wait = io_wait_q[CORE_ADDR[10:IO_REGION_LSB] * 3 +: 3];
    assign core_target = (CORE_IO_REQ ? {1'b0, io_wait} : {1'b0, data_ext_wait_q})
        + SYNC_CYCLES;
    // Core waits behind a byte access already on the pins, never at start.
    assign core_drive = core_ext && !bact_q && !BUS_GRANT;
    assign CORE_WAIT = core_ext && !(core_drive && ccnt_q == core_target);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ccnt_q <= 4'h0;
        end else if (core_drive && ccnt_q != core_target) begin
            ccnt_q <= ccnt_q + 4'h1;
        end else begin
            ccnt_q <= 4'h0;
        end
    end

    // Pin data passes a two-stage synchroniser before anyone reads it.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_s1 <= 24'h000000;
            ext_s2 <= 24'h000000;
        end else begin
            ext_s1 <= EXT_DATA_I;
            ext_s2 <= ext_s1;
        end
    end
    assign CORE_RDATA = ext_s2[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: byte access, or core access, or nothing.
    assign PIN_OE = !BUS_GRANT;
    assign BMS_N = !bact_q;
    assign PMS_N = !(core_drive && CORE_PM_REQ);
    assign DMS_N = !(core_drive && dm_ext);
    assign IO_SPACE_STROBE_N = !(core_drive && CORE_IO_REQ);
    assign CMS_N =
        !(|(sel_en_q & {!IO_SPACE_STROBE_N, !BMS_N, !DMS_N, !PMS_N}));
    assign RD_N = bact_q ? dir_q : !(core_drive && !CORE_WE);
    assign WR_N = bact_q ? !dir_q : !(core_drive && CORE_WE);

    always_comb begin
        EXT_ADDR = 14'h0000;
        EXT_DATA_O = 24'h000000;
        EXT_DATA_OE = 3'h0;
        if (bact_q) begin
            EXT_ADDR = ext_q;
            EXT_DATA_O = {page_q, word_q[23:16], 8'h00};
            EXT_DATA_OE = {1'b1, dir_q, 1'b0};
        end else if (core_drive) begin
            if (CORE_IO_REQ) begin
                EXT_ADDR = {3'h0, CORE_ADDR[10:0]};
            end else if (dm_ext) begin
                EXT_ADDR = {overlay_q == OVERLAY_TWO,
                    CORE_ADDR[12:0]};
            end else begin
                EXT_ADDR = CORE_ADDR;
            end
            EXT_DATA_O = {8'h00, CORE_WDATA};
            EXT_DATA_OE = CORE_WE ? 3'h3 : 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte DMA engine.
    assign byte_end = bact_q
        && bcnt_q == {1'b0, bwait_q} + SYNC_CYCLES;
    assign word_done = (bst_q == B_STORE && !host_acc)
        || (byte_end && dir_q && idx_q == last_byte(fmt_q));

    always_comb begin
        unique case (fmt_q)
            FMT_PM24: store_word = word_q;
            FMT_DM16: store_word = {8'h00, word_q[15:0]};
            FMT_MSB: store_word = {8'h00, word_q[7:0], 8'h00};
            default: store_word = {16'h0000, word_q[7:0]};
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bst_q <= B_IDLE;
            bact_q <= 1'b0;
            bcnt_q <= 4'h0;
            idx_q <= 2'h0;
            word_q <= 24'h000000;
        end else begin
            unique case (bst_q)
                B_IDLE: begin
                    idx_q <= 2'h0;
                    if (count_q != 14'h0000) begin
                        bst_q <= dir_q ? B_FETCH : B_BYTE;
                    end
                end
                B_FETCH: begin
                    if (!host_acc) begin
                        bst_q <= B_LOAD;
                    end
                end
                B_LOAD: begin
                    unique case (fmt_q)
                        FMT_PM24: word_q <= MEM_RDATA;
                        FMT_DM16: word_q <= {MEM_RDATA[15:0], 8'h00};
                        FMT_MSB: word_q <= {MEM_RDATA[15:8], 16'h0000};
                        default: word_q <= {MEM_RDATA[7:0], 16'h0000};
                    endcase
                    bst_q <= B_BYTE;
                end
                B_BYTE: begin
                    if (!bact_q) begin
                        if (!core_ext && !BUS_GRANT) begin
                            bact_q <= 1'b1;
                            bcnt_q <= 4'h0;
                        end
                    end else if (!byte_end) begin
                        bcnt_q <= bcnt_q + 4'h1;
                    end else begin
                        bact_q <= 1'b0;
                        idx_q <= idx_q + 2'h1;
                        word_q <= dir_q ? {word_q[15:0], 8'h00}
                            : {word_q[15:0], ext_s2[15:8]};
                        if (idx_q == last_byte(fmt_q)) begin
                            bst_q <= dir_q ? B_IDLE : B_STORE;
                        end
                    end
                end
                B_STORE: begin
                    idx_q <= 2'h0;
                    if (!host_acc) begin
                        bst_q <= B_IDLE;
                    end
                end
                default: bst_q <= B_IDLE;
            endcase
        end
    end

    // Transfer addresses and count; the engine steps them as it runs.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            int_q <= 14'h0000;
            ext_q <= 14'h0000;
            page_q <= 8'h00;
            count_q <= 14'h0000;
        end else begin
            if (byte_end) begin
                {page_q, ext_q} <= {page_q, ext_q} + 22'h000001;
            end else if (REG_WR && REG_ADDR == REG_XFER_EXT) begin
                ext_q <= REG_WDATA[13:0];
            end else if (REG_WR && REG_ADDR == REG_XFER_PAGE) begin
                page_q <= REG_WDATA[7:0];
            end
            if (word_done) begin
                int_q <= int_q + 14'h0001;
            end else if (REG_WR && REG_ADDR == REG_XFER_INT) begin
                int_q <= REG_WDATA[13:0];
            end
            if (count_wr) begin
                count_q <= REG_WDATA[13:0];
            end else if (word_done) begin
                count_q <= count_q - 14'h0001;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            irq_q <= word_done && !count_wr && count_q == 14'h0001;
            restart_q <= word_done && !count_wr && count_q == 14'h0001
                && hold_q;
        end
    end
    assign BYTE_DMA_IRQ = irq_q;
    assign CORE_RESTART = restart_q;
    assign CORE_HOLD = hold_q && count_q != 14'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Host DMA port.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hp_s1 <= 4'hf;
            hp_s2 <= 4'hf;
            hlatch_s3 <= 1'b1;
            had_s1 <= 16'h0000;
            had_s2 <= 16'h0000;
        end else begin
            hp_s1 <= {HOST_ADDR_LATCH_N, HOST_SELECT_N, HOST_READ_N,
                HOST_WRITE_N};
            hp_s2 <= hp_s1;
            hlatch_s3 <= hp_s2[3];
            had_s1 <= HOST_AD_I;
            had_s2 <= had_s1;
        end
    end
    assign host_req = !hp_s2[2] && (!hp_s2[1] || !hp_s2[0]);
    assign host_acc = hst_q == H_ACC;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hst_q <= H_IDLE;
            haddr_q <= 14'h0000;
            hpm_q <= 1'b0;
            hwe_q <= 1'b0;
            hrdata_q <= 16'h0000;
        end else begin
            unique case (hst_q)
                H_IDLE: begin
                    if (hlatch_s3 && !hp_s2[3]) begin
                        haddr_q <= had_s2[13:0];
                        hpm_q <= had_s2[14];
                    end else if (host_req) begin
                        hwe_q <= !hp_s2[0];
                        hst_q <= H_SYNC;
                    end
                end
                H_SYNC: hst_q <= H_ACC;
                H_ACC: begin
                    haddr_q <= haddr_q + 14'h0001;
                    hst_q <= H_DONE;
                end
                H_DONE: begin
                    if (!hwe_q) begin
                        hrdata_q <= hpm_q ? MEM_RDATA[23:8] : MEM_RDATA[15:0];
                        hwe_q <= 1'b1;
                    end
                    if (!host_req) begin
                        hst_q <= H_IDLE;
                    end
                end
            endcase
        end
    end
    assign HOST_ACK_N = hst_q == H_SYNC || hst_q == H_ACC;
    assign HOST_AD_O = hrdata_q;
    assign HOST_AD_OE = !hp_s2[2] && !hp_s2[1];

    ////////////////////////////////////////////////////////////////////////
    // On-chip memory port; the host wins a clash with the engine.
    always_comb begin
        MEM_REQ = 1'b0;
        MEM_PM = fmt_q == FMT_PM24;
        MEM_WE = 1'b0;
        MEM_ADDR = int_q;
        MEM_WDATA = store_word;
        if (host_acc) begin
            MEM_REQ = 1'b1;
            MEM_PM = hpm_q;
            MEM_WE = hwe_q;
            MEM_ADDR = haddr_q;
            MEM_WDATA = hpm_q ? {had_s2, 8'h00} : {8'h00, had_s2};
        end else if (bst_q == B_FETCH || bst_q == B_STORE) begin
            MEM_REQ = 1'b1;
            MEM_WE = bst_q == B_STORE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_seen_q <= 1'b0;
        end else if (REG_WR && REG_ADDR == REG_SEL_EN) begin
            sel_seen_q <= 1'b1;
        end
    end

    a_sel_reset: assert property (
        !sel_seen_q |-> !CMS_N == (!PMS_N || !DMS_N || !IO_SPACE_STROBE_N))
        else $error("select enables not at reset");
    a_int_no_wait: assert property (
        CORE_DM_INTERNAL && !CORE_IO_REQ && !CORE_PM_REQ |-> !CORE_WAIT)
        else $error("internal stalled");
    a_overlay_bit: assert property (
        !DMS_N |-> EXT_ADDR[13] == (overlay_q == OVERLAY_TWO)
        && !CORE_ADDR[13])
        else $error("bad overlay");
    a_io_upper: assert property (
        !IO_SPACE_STROBE_N |-> EXT_ADDR[13:11] == 3'h0)
        else $error("io upper bits driven");
    a_cms_follow: assert property (
        !DMS_N && sel_en_q[SEL_DM] |-> !CMS_N)
        else $error("combined select missed");
    a_grant_off: assert property (
        BUS_GRANT |-> !PIN_OE && BMS_N && DMS_N)
        else $error("pins driven under grant");
    a_byte_page: assert property (
        !BMS_N |-> EXT_DATA_O[23:16] == page_q && EXT_ADDR == ext_q)
        else $error("byte address wrong");
    a_count_step: assert property (
        word_done && !count_wr |=> count_q == $past(count_q) - 14'h0001)
        else $error("count not stepped");
    a_core_first: assert property (
        bst_q == B_BYTE && !bact_q && core_ext |=> !bact_q)
        else $error("byte access beat core");
    a_one_steal: assert property (
        bst_q == B_STORE && !host_acc |=> bst_q == B_IDLE)
        else $error("steal longer than one cycle");
    a_host_incr: assert property (
        host_acc |=> haddr_q == $past(haddr_q) + 14'h0001
        && hst_q == H_DONE)
        else $error("host address");
    a_stop_zero: assert property (
        count_q == 14'h0000 && bst_q == B_IDLE |-> BMS_N)
        else $error("byte strobe at zero");

    c_dma_done: cover property (irq_q);
    c_host_write: cover property (host_acc && hwe_q);
    c_page_cross: cover property (byte_end && ext_q == 14'h3fff);
    c_core_clash: cover property (bact_q && core_ext);
endmodule
`default_nettype wire

/* File: verif/emd_ext_model.sv */
// Purpose: Byte and word memory model on the external bus pins.
// Assumes: Read data follow strobe and address at once, as in an async part.
// Notes: Unselected data lines show the inverse of their last value.
`default_nettype none
module emd_ext_model (
    // Clock.
    input wire logic clk,
    // Bus from the device.
    input wire logic [13:0] addr,
    input wire logic [23:0] dout,
    input wire logic rd_n,
    input wire logic bms_n,
    input wire logic word_n,
    // Read data back to the device.
    output logic [23:0] din
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [23:0] last_q = '0;
    // A byte's value mixes its in-page address with the page lines.
    always_comb begin
        if (!rd_n && !bms_n)
            din = {8'h0, addr[7:0] ^ dout[23:16], 8'h0};
        else if (!rd_n && !word_n)
            din = {10'h0, addr};
        else
            din = ~last_q;
    end
    always @(posedge clk)
        last_q <= din;
endmodule
`default_nettype wire

/* File: verif/tb_external_memory_and_dma_ports.sv */
// Purpose: Self-checking bench of the memory and DMA block.
// Assumes: Memory model on the external pins, bench on all other ports.
// Notes: Random values come from a fixed-seed shift register.
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
    $display("unexpected %s exp %h got %h", n, e, s); bad_count++; end end
module tb_external_memory_and_dma_ports;
    import emd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, rw = 0, rr = 0, bg = 0, dmq = 0, ioq = 0;
    logic hl_n = 1, hs_n = 1, hw_n = 1, hr_n = 1, dmi, wt, pin_oe, irq, mreq;
    logic rd_n, bms_n, dms_n, io_space_strobe_n, cms_n, cs, il, wr_n, hld, crs;
    logic [15:0] had_o;
    logic [3:0] ra = '0;
    logic [15:0] wd = '0, rdat, had = '0, rv, seed = 16'hcde9;
    logic [13:0] ca = '0, ext_addr, maddr, ea;
    logic [23:0] dout, din, mwd, mrd = '0, wb;
    logic [7:0] p;
    logic [2:0] dw, bw;
    logic [11:0] iow;
    logic [13:0] ma[$];
    logic [23:0] md[$];
    int bad_count = 0, n_compared = 0, w, k, bl = 0, nirq = 0, nrs = 0, bq[$];
    emd_top uut (.CLK(clk), .RESET_N(rst_n), .REG_ADDR(ra), .REG_WDATA(wd),
        .REG_WR(rw), .REG_RD(rr), .REG_RDATA(rdat), .CORE_PM_REQ(1'b0),
        .CORE_DM_REQ(dmq), .CORE_IO_REQ(ioq), .CORE_WE(1'b0), .CORE_ADDR(ca),
        .CORE_WDATA(16'h0), .CORE_RDATA(), .CORE_WAIT(wt),
        .CORE_DM_INTERNAL(dmi), .CORE_HOLD(hld), .CORE_RESTART(crs),
        .BYTE_DMA_IRQ(irq),
        .BUS_GRANT(bg), .EXT_ADDR(ext_addr), .EXT_DATA_O(dout),
        .EXT_DATA_I(din), .EXT_DATA_OE(), .PIN_OE(pin_oe), .RD_N(rd_n),
        .WR_N(wr_n), .PMS_N(), .DMS_N(dms_n), .BMS_N(bms_n), .IO_SPACE_STROBE_N(io_space_strobe_n),
        .CMS_N(cms_n), .MEM_REQ(mreq), .MEM_PM(), .MEM_WE(), .MEM_ADDR(maddr),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd), .HOST_ADDR_LATCH_N(hl_n),
        .HOST_SELECT_N(hs_n), .HOST_READ_N(hr_n), .HOST_WRITE_N(hw_n),
        .HOST_AD_I(had), .HOST_AD_O(had_o), .HOST_AD_OE(), .HOST_ACK_N());
    emd_ext_model mem (.clk(clk), .addr(ext_addr), .dout(dout), .rd_n(rd_n),
        .bms_n(bms_n), .word_n(dms_n & io_space_strobe_n), .din(din));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Records on-chip accesses, interrupt pulses and byte strobe lengths.
    always @(posedge clk) begin
        if (mreq) begin
            ma.push_back(maddr);
            md.push_back(mwd);
        end
        if (irq)
            nirq++;
        if (crs)
            nrs++;
        if (!bms_n) begin
            if (bl == 0 && !wr_n)
                wb = {wb[15:0], dout[15:8]};
            bl++;
        end else if (bl != 0) begin
            bq.push_back(bl);
            bl = 0;
        end
    end
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ra <= a;
        wd <= d;
        rw <= 1'b1;
        @(posedge clk);
        rw <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        ra <= a;
        rr <= 1'b1;
        @(posedge clk);
        rr <= 1'b0;
        @(negedge clk);
        d = rdat;
        @(posedge clk);
    endtask
    // Core access held until the wait output is low at a rising edge.
    task automatic acc(input logic io, input logic [13:0] a);
        ca <= a;
        dmq <= !io;
        ioq <= io;
        w = 0;
        @(negedge clk);
        ea = ext_addr;
        cs = cms_n;
        il = dmi;
        while (wt !== 1'b0 && w < 20) begin
            w++;
            @(negedge clk);
        end
        @(posedge clk);
        dmq <= 1'b0;
        ioq <= 1'b0;
        @(posedge clk);
    endtask
    task automatic hwr(input logic r, input logic [15:0] d);
        had <= d;
        hs_n <= 1'b0;
        hr_n <= !r;
        hw_n <= r;
        repeat (6) @(posedge clk);
        hs_n <= 1'b1;
        hr_n <= 1'b1;
        hw_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        mrd <= {seed, seed[7:0]};
        @(posedge clk);
        rd(REG_SEL_EN, rv);
        `CHK("sel_en", SEL_EN_RESET, rv[3:0])
        rd(4'hf, rv);
        `CHK("unmapped", 16'h0, rv)
        seed = lf(seed);
        dw = seed[2:0];
        bw = seed[5:3];
        iow = seed[15:4];
        wr(REG_WAITS, {10'h0, bw, dw});
        wr(REG_IO_WAITS, {4'h0, iow});
        acc(1'b0, 14'h0123);
        `CHK("int_wait", 0, w)
        `CHK("dm_int", 1'b1, il)
        // Overlay two puts the low data half on the second external overlay.
        wr(REG_OVERLAY, {8{OVERLAY_TWO}});
        acc(1'b0, 14'h1abc);
        `CHK("dm_int", 1'b0, il)
        `CHK("ovl_addr", 14'h3abc, ea)
        `CHK("dm_wait", dw + 2, w)
        `CHK("cms_dm", 1'b0, cs)
        acc(1'b0, 14'h2100);
        `CHK("dm_int", 1'b1, il)
        for (k = 0; k < 4; k++) begin
            seed = lf(seed);
            acc(1'b1, {3'h0, k[1:0], seed[8:0]});
            `CHK("io_addr", {k[1:0], seed[8:0]}, ea[10:0])
            `CHK("io_wait", iow[3*k+:3] + 2, w)
            `CHK("cms_io", 1'b0, cs)
        end
        seed = lf(seed);
        p = seed[7:0];
        wr(REG_XFER_CTRL, 16'h0003);
        wr(REG_XFER_INT, 16'h0040);
        wr(REG_XFER_EXT, 16'h3fff);
        wr(REG_XFER_PAGE, {8'h0, p});
        wr(REG_XFER_COUNT, 16'h0002);
        for (k = 0; k < 500 && nirq == 0; k++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        `CHK("int_adr0", 14'h0040, ma[0])
        `CHK("int_adr1", 14'h0041, ma[1])
        `CHK("word0", {16'h0, 8'hff ^ p}, md[0])
        `CHK("word1", {16'h0, p + 8'h1}, md[1])
        `CHK("bms_len", bw + 3, bq[0])
        `CHK("n_bytes", 2, bq.size())
        `CHK("n_irq", 1, nirq)
        rd(REG_XFER_COUNT, rv);
        `CHK("count", 16'h0, rv)
        // Program word out to byte memory with the core held off.
        wr(REG_XFER_CTRL, 16'h000c);
        wr(REG_XFER_COUNT, 16'h0001);
        `CHK("hold", 1'b1, hld)
        for (k = 0; k < 500 && nirq < 2; k++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        `CHK("wr_bytes", mrd, wb)
        `CHK("restart", 1, nrs)
        `CHK("hold_off", 1'b0, hld)
        bg <= 1'b1;
        @(negedge clk);
        `CHK("pin_oe", 1'b0, pin_oe)
        @(posedge clk);
        bg <= 1'b0;
        had <= 16'h0155;
        hl_n <= 1'b0;
        repeat (4) @(posedge clk);
        hl_n <= 1'b1;
        repeat (4) @(posedge clk);
        k = ma.size();
        hwr(1'b0, seed);
        hwr(1'b0, ~seed);
        hwr(1'b1, 16'h0000);
        `CHK("host_adr", 14'h0155, ma[k])
        `CHK("host_dat", seed, md[k][15:0])
        `CHK("host_inc", 14'h0156, ma[k+1])
        `CHK("host_rd", mrd[15:0], had_o)
        end_of_test;
    end
endmodule
`default_nettype wire
